// ---- swk_consts.vh ----
`ifndef SWK_CONSTS_VH
`define SWK_CONSTS_VH
// clock period in ps (250 MHz)
`define SWK_CLK_PS 4000
// deglitch filter interval in ns, least figure
`define SWK_FILTER_NS 160
`define SWK_FILTER_CYC ((`SWK_FILTER_NS * 1000 + `SWK_CLK_PS - 1) / `SWK_CLK_PS)
// fixed delay from request low to input re-enable, in sys_clk cycles
`define SWK_ENABLE_CYC 8
// delay from request high to input block, in sys_clk cycles
`define SWK_DISABLE_CYC 4
// default wake timer release counts
`define SWK_OUT_REL_DEF 10'h004
`define SWK_WR_REL_DEF 10'h005
// configuration defaults
`define SWK_EN_DEF 1'b0
// simulated configuration load time in cycles
`define SWK_CFG_CYC 16
// sequencer states
`define SWK_ST_CFG 3'h0
`define SWK_ST_RUN 3'h1
`define SWK_ST_ENTER 3'h2
`define SWK_ST_SLEEP 3'h3
`define SWK_ST_WAKEIN 3'h4
`define SWK_ST_WAITAWK 3'h5
`define SWK_ST_TIMERS 3'h6
// apb register offsets
`define SWK_REG_CTRL 12'h000
`define SWK_REG_OUTCNT 12'h004
`define SWK_REG_WRCNT 12'h008
`define SWK_REG_STAT 12'h00C
// control register bit positions
`define SWK_CTRL_EN 0
`define SWK_CTRL_FILT 1
`define SWK_CTRL_DRV 2
`define SWK_CTRL_GSR 3
`define SWK_CTRL_WCLK 4
`endif

// ---- swk_sequencer.v ----
// The APB register port and the register offsets were decided locally.
`include "swk_consts.vh"
module swk_sequencer #(
   parameter CNT_W = 10,
   parameter NPINS = 8
)(
   // clock and reset
   input wire sys_clk,
   input wire rst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // pins from system controller
   input wire sleep_req,
   input wire reconfig_n,
   input wire wake_in,
   input wire alt_wake_clk,
   // wake status pin, open-drain capable
   output reg wake_out,
   output reg wake_oe,
   // per-pin output behaviour
   input wire [NPINS-1:0] user_out,
   output reg [NPINS-1:0] hold_value,
   output reg sleep_outputs,
   // global controls
   output reg write_protect,
   output reg inputs_blocked,
   output reg global_sr,
   output reg config_done
);
   // synchronisers
   reg req_s1;
   reg req_s2;
   reg rcf_s1;
   reg rcf_s2;
   reg wk_s1;
   reg wk_s2;
   reg ck_s1;
   reg ck_s2;
   reg ck_s3;
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         rcf_s1 <= 1'b1;
         rcf_s2 <= 1'b1;
         wk_s1 <= 1'b0;
         wk_s2 <= 1'b0;
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_s3 <= 1'b0;
      end
      else
      begin
         req_s1 <= sleep_req;
         req_s2 <= req_s1;
         rcf_s1 <= reconfig_n;
         rcf_s2 <= rcf_s1;
         wk_s1 <= wake_in;
         wk_s2 <= wk_s1;
         ck_s1 <= alt_wake_clk;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
      end
   end

   // configuration registers
   reg [4:0] ctrl;
   reg [CNT_W-1:0] out_rel_count;
   reg [CNT_W-1:0] wr_rel_count;
   wire acc = psel && penable;
   wire wr_en = acc && pwrite;
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= {4'h0, `SWK_EN_DEF};
         out_rel_count <= `SWK_OUT_REL_DEF;
         wr_rel_count <= `SWK_WR_REL_DEF;
      end
      else if (wr_en)
      begin
         if (paddr == `SWK_REG_CTRL)
            ctrl <= pwdata[4:0];
         if (paddr == `SWK_REG_OUTCNT)
            out_rel_count <= pwdata[CNT_W-1:0];
         if (paddr == `SWK_REG_WRCNT)
            wr_rel_count <= pwdata[CNT_W-1:0];
      end
   end

   // deglitch filter on rising request
   localparam FW = 8;
   reg [FW-1:0] filt_cnt;
   reg req_f;
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         filt_cnt <= 8'h00;
         req_f <= 1'b0;
      end
      else if (!req_s2)
      begin
         filt_cnt <= 8'h00;
         req_f <= 1'b0;
      end
      else if (!ctrl[`SWK_CTRL_FILT])
         req_f <= 1'b1;
      // full interval counted, so the added delay never falls short of the minimum
      else if (filt_cnt == `SWK_FILTER_CYC)
         req_f <= 1'b1;
      else
         filt_cnt <= filt_cnt + 8'h01;
   end

   // wake clock tick: internal every cycle, or rising edge of alternate
   wire wclk_tick = ctrl[`SWK_CTRL_WCLK] ? (ck_s2 && !ck_s3) : 1'b1;
   wire req_on = req_f && ctrl[`SWK_CTRL_EN];

   reg [2:0] state;
   reg [CNT_W-1:0] cnt;
   reg [CNT_W-1:0] wcnt;
   // compare on the count after this tick, so release lands on the counted cycle
   wire [CNT_W-1:0] next_wcnt = wclk_tick ? wcnt + 1'b1 : wcnt;
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= `SWK_ST_CFG;
         cnt <= {CNT_W{1'b0}};
         wcnt <= {CNT_W{1'b0}};
         config_done <= 1'b0;
         write_protect <= 1'b0;
         sleep_outputs <= 1'b0;
         inputs_blocked <= 1'b0;
         wake_out <= 1'b1;
         wake_oe <= 1'b1;
         global_sr <= 1'b0;
         hold_value <= {NPINS{1'b0}};
      end
      else if (!rcf_s2)
      begin
         // reconfiguration wins over every state
         state <= `SWK_ST_CFG;
         cnt <= {CNT_W{1'b0}};
         config_done <= 1'b0;
         write_protect <= 1'b0;
         sleep_outputs <= 1'b0;
         inputs_blocked <= 1'b0;
         wake_out <= 1'b1;
         wake_oe <= 1'b1;
         global_sr <= 1'b0;
      end
      else
      begin
         global_sr <= 1'b0;
         case (state)
            `SWK_ST_CFG:
            begin
               // request level ignored while loading
               if (cnt == `SWK_CFG_CYC - 1)
               begin
                  config_done <= 1'b1;
                  state <= `SWK_ST_RUN; // re-sleep follows if held high
                  cnt <= {CNT_W{1'b0}};
               end
               else
                  cnt <= cnt + 1'b1;
            end
            `SWK_ST_RUN:
               if (req_on)
               begin
                  hold_value <= user_out;
                  write_protect <= 1'b1;
                  wake_out <= 1'b0;
                  wake_oe <= 1'b1;
                  cnt <= {CNT_W{1'b0}};
                  state <= `SWK_ST_ENTER;
               end
            `SWK_ST_ENTER:
            begin
               sleep_outputs <= 1'b1;
               if (cnt == `SWK_DISABLE_CYC - 1)
               begin
                  inputs_blocked <= 1'b1;
                  state <= `SWK_ST_SLEEP;
               end
               cnt <= cnt + 1'b1;
            end
            `SWK_ST_SLEEP:
               // config_done untouched while sleeping
               if (!req_s2)
               begin
                  cnt <= {CNT_W{1'b0}};
                  state <= `SWK_ST_WAKEIN;
               end
            `SWK_ST_WAKEIN:
               if (cnt == `SWK_ENABLE_CYC - 1)
               begin
                  inputs_blocked <= 1'b0;
                  global_sr <= ctrl[`SWK_CTRL_GSR];
                  if (ctrl[`SWK_CTRL_DRV])
                  begin
                     wake_out <= 1'b1;
                     wake_oe <= 1'b1;
                  end
                  else
                  begin
                     wake_out <= 1'b0;
                     wake_oe <= 1'b0;
                  end
                  state <= `SWK_ST_WAITAWK;
               end
               else
                  cnt <= cnt + 1'b1;
            `SWK_ST_WAITAWK:
               // released pin waits for an outside pull-up
               if (wake_oe || wk_s2)
               begin
                  wcnt <= {CNT_W{1'b0}};
                  state <= `SWK_ST_TIMERS;
               end
            `SWK_ST_TIMERS:
            begin
               wcnt <= next_wcnt;
               if (next_wcnt >= out_rel_count)
                  sleep_outputs <= 1'b0;
               if (next_wcnt >= wr_rel_count)
                  write_protect <= 1'b0;
               if (next_wcnt >= out_rel_count && next_wcnt >= wr_rel_count)
               begin
                  wake_out <= 1'b1;
                  wake_oe <= 1'b1;
                  state <= `SWK_ST_RUN;
               end
            end
            default:
               state <= `SWK_ST_CFG;
         endcase
      end
   end

   // apb read side, zero wait states
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel && !penable)
         begin
            case (paddr)
               `SWK_REG_CTRL: prdata <= {27'h0, ctrl};
               `SWK_REG_OUTCNT: prdata <= {{(32-CNT_W){1'b0}}, out_rel_count};
               `SWK_REG_WRCNT: prdata <= {{(32-CNT_W){1'b0}}, wr_rel_count};
               `SWK_REG_STAT: prdata <= {22'h0, state, config_done, write_protect,
                  sleep_outputs, inputs_blocked, wake_out, wake_oe, req_f};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// ---- swk_seq_properties.sv ----
module swk_seq_chk (
   // clock and reset
   input wire sys_clk,
   input wire rst_n,
   // apb handshake
   input wire psel,
   input wire penable,
   input wire pready,
   // wake pin
   input wire wake_in,
   input wire wake_out,
   input wire wake_oe,
   // global controls
   input wire sleep_outputs,
   input wire write_protect,
   input wire inputs_blocked,
   input wire config_done
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   a_apb_fixed_wait: assert property (psel && !penable |=> pready)
      else $error("ready not one cycle after setup");
   a_wake_low_lock: assert property ($rose(write_protect) |-> !wake_out && wake_oe)
      else $error("wake pin not driven low at lock");
   a_outs_after_lock: assert property ($rose(write_protect) |=> sleep_outputs)
      else $error("outputs not switched after lock");
   a_block_last: assert property ($rose(inputs_blocked) |-> sleep_outputs && write_protect)
      else $error("inputs blocked too early");
   a_unblock_locked: assert property ($fell(inputs_blocked) && config_done |-> write_protect)
      else $error("inputs released without lock");
   a_done_sleeping: assert property ($rose(sleep_outputs) |-> config_done)
      else $error("done low while sleeping");
   a_timer_after_wake: assert property ($fell(sleep_outputs) && config_done |-> wake_in)
      else $error("outputs released before wake high");
   a_outs_before_wr: assert property ($fell(write_protect) && config_done |-> !sleep_outputs)
      else $error("writes released before outputs");
endmodule
bind swk_sequencer swk_seq_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pready(pready), .wake_in(wake_in), .wake_out(wake_out),
   .wake_oe(wake_oe), .sleep_outputs(sleep_outputs), .write_protect(write_protect),
   .inputs_blocked(inputs_blocked), .config_done(config_done));

// ---- swk_ctl_model.sv ----
module swk_ctl_model (
   // clock
   input wire sys_clk,
   // commands from bench
   input wire want_sleep,
   input wire want_reconf,
   input wire hold_wake,
   // wake pin from device
   input wire wake_out,
   input wire wake_oe,
   // pins to device
   output logic sleep_req = 1'b0,
   output logic reconfig_n = 1'b1,
   output logic wake_in,
   output logic alt_wake_clk = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge sys_clk)
   begin
      sleep_req <= want_sleep;
      reconfig_n <= !want_reconf;
      alt_wake_clk <= !alt_wake_clk;
   end
   // shared pull-up line, another party may clamp it low
   assign wake_in = (wake_oe ? wake_out : 1'b1) && !hold_wake;
endmodule

// ---- swk_sequencer_tb.sv ----
`include "swk_consts.vh"
module swk_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err_flag;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, sleep_req, reconfig_n, wake_in, alt_wake_clk, wake_out, wake_oe;
   logic want_sleep = 1, want_reconf = 0, hold_wake = 0, gsr_seen = 0;
   logic [7:0] user_out = 8'hA5, hold_value;
   logic sleep_outputs, write_protect, inputs_blocked, global_sr, config_done;
   int err_count = 0, n_checks = 0, cyc = 0, t0, t1, lat0;
   swk_sequencer dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .reconfig_n(reconfig_n), .wake_in(wake_in),
      .alt_wake_clk(alt_wake_clk), .wake_out(wake_out), .wake_oe(wake_oe),
      .user_out(user_out), .hold_value(hold_value), .sleep_outputs(sleep_outputs),
      .write_protect(write_protect), .inputs_blocked(inputs_blocked),
      .global_sr(global_sr), .config_done(config_done));
   swk_ctl_model ctl_u (.sys_clk(sys_clk), .want_sleep(want_sleep), .want_reconf(want_reconf),
      .hold_wake(hold_wake), .wake_out(wake_out), .wake_oe(wake_oe), .sleep_req(sleep_req),
      .reconfig_n(reconfig_n), .wake_in(wake_in), .alt_wake_clk(alt_wake_clk));
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (global_sr === 1'b1)
         gsr_seen <= 1;
      if (cyc == 20000)
      begin
         err_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
      rd = prdata;
      err_flag = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // bounded wait, counts cycles until the level shows
   task automatic wait_for(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 2000)
      begin
         @(posedge sys_clk);
         n++;
      end
      check("wait", n < 2000, 1);
   endtask
   task automatic go_sleep(output int lat);
      int n;
      want_sleep <= 1;
      @(posedge sys_clk);
      wait_for(wake_out, 0, lat);
      wait_for(inputs_blocked, 1, n);
   endtask
   task automatic open_drain_wake();
      apb(1, `SWK_REG_CTRL, 32'h1);
      hold_wake <= 1;
      user_out <= 8'h5A;
      go_sleep(lat0);
      user_out <= 8'h00;
      @(posedge sys_clk);
      check("hold", hold_value, 8'h5A);
      check("lock", write_protect, 1);
      check("outs", sleep_outputs, 1);
      check("wake", {wake_oe, wake_out}, 2'b10);
      check("done", config_done, 1);
      want_sleep <= 0;
      wait_for(inputs_blocked, 0, t1);
      check("lock_unblk", write_protect, 1);
      repeat (30) @(posedge sys_clk);
      check("held", sleep_outputs, 1);
      check("oe_rel", wake_oe, 0);
      hold_wake <= 0;
      wait_for(sleep_outputs, 0, t0);
      wait_for(write_protect, 0, t1);
      check("out_rel", t0 inside {[4:8]}, 1);
      check("gap", t1, 1);
      check("no_sr", gsr_seen, 0);
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1;
      wait_for(config_done, 1, t0);
      repeat (20) @(posedge sys_clk);
      check("ignored", {write_protect, wake_out}, 2'b01);
      want_sleep <= 0;
      apb(0, `SWK_REG_CTRL, 0);
      check("ctrl", rd, 0);
      apb(0, `SWK_REG_OUTCNT, 0);
      check("outcnt", rd, 32'h4);
      apb(0, `SWK_REG_WRCNT, 0);
      check("wrcnt", rd, 32'h5);
      apb(0, 12'h010, 0);
      check("slverr", err_flag, 1);
      open_drain_wake();
      apb(1, `SWK_REG_CTRL, 32'h1D);
      go_sleep(t0);
      want_sleep <= 0;
      wait_for(wake_out, 1, t0);
      wait_for(sleep_outputs, 0, t1);
      check("altclk", t1 >= 7, 1);
      wait_for(write_protect, 0, t0);
      check("drv", {wake_oe, wake_out}, 2'b11);
      check("sr", gsr_seen, 1);
      apb(1, `SWK_REG_CTRL, 32'h3);
      go_sleep(t1);
      check("filt", t1 - lat0 >= 40, 1);
      check("filt_max", t1 - lat0 <= 150, 1);
      want_reconf <= 1;
      repeat (4) @(posedge sys_clk);
      want_reconf <= 0;
      wait_for(config_done, 0, t0);
      check("ovr", sleep_outputs, 0);
      wait_for(config_done, 1, t0);
      wait_for(write_protect, 1, t0);
      check("resleep", wake_out, 0);
      want_sleep <= 0;
      summarize();
   end
endmodule
